//--- hw/dmc_device.sv
`timescale 1ns/1ps
module dmc_frame_meter (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic level_in,
	output logic rise_out,
	output logic [dmc_pkg::PERIOD_W-1:0] period_out,
	output logic slip_out
);
	logic prev;
	logic have_period;
	logic [dmc_pkg::PERIOD_W-1:0] count;
	wire rise = level_in & ~prev;
	wire saturated = &count;
	wire [dmc_pkg::PERIOD_W-1:0] new_period = count + 16'h0001;
	wire [dmc_pkg::PERIOD_W-1:0] diff = (new_period > period_out) ?
		(new_period - period_out) : (period_out - new_period);
	assign rise_out = rise;
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prev <= 1'b0;
			have_period <= 1'b0;
			count <= '0;
			period_out <= '0;
			slip_out <= 1'b0;
		end else begin
			prev <= level_in;
			count <= rise ? '0 : (saturated ? count : new_period);
			if (rise) begin
				period_out <= new_period;
				have_period <= 1'b1;
			end
			// A stopped clock counts as lost sync once the counter saturates
			slip_out <= (rise & have_period & (diff > dmc_pkg::SYNC_TOL)) |
				(saturated & have_period & ~rise);
			if (saturated & ~rise) begin
				have_period <= 1'b0;
			end
		end
	end
endmodule : dmc_frame_meter

module dmc_device (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	dmc_link_if.device link,
	input wire logic [dmc_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [dmc_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [dmc_pkg::DATA_W-1:0] reg_rdata_out,
	output logic quiescent_reference_out,
	output logic [1:0] speed_mode_out,
	output logic [2:0] iface_format_out,
	output logic deemphasis_out,
	output logic bitstream_mode_out,
	output logic [7:0] oversample_ratio_out,
	output logic [3:0] bitstream_ratio_out,
	output logic filter_rolloff_out,
	output logic ratio_ok_out,
	output logic retiming_out,
	output logic [3:0] pair_active_out,
	output logic [3:0] mute_out,
	output logic [dmc_pkg::NUM_INPUTS*dmc_pkg::SAMPLE_W-1:0] sample_word_out,
	output logic [dmc_pkg::NUM_INPUTS-1:0] sample_valid_out
);
	localparam int NI = dmc_pkg::NUM_INPUTS;
	localparam int SW = dmc_pkg::SAMPLE_W;
	localparam int LW = 4 + 4 + NI;
	wire [LW-1:0] link_raw = {link.mode_strap, link.frame_clock_one, link.bit_clock_one,
		link.frame_clock_two, link.bit_clock_two, link.serial_data_input};
	logic [LW-1:0] sync_a;
	logic [LW-1:0] sync_b;
	logic [LW-1:0] sync_c;
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
		end else begin
			sync_a <= link_raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end
	wire [3:0] strap_now = sync_b[LW-1 -: 4];
	wire [3:0] strap_prev = sync_c[LW-1 -: 4];
	wire fc1 = sync_b[NI+3];
	wire bc1_rise = sync_b[NI+2] & ~sync_c[NI+2];
	wire fc2 = sync_b[NI+1];
	wire bc2_rise = sync_b[NI] & ~sync_c[NI];
	wire fc1_edge = sync_b[NI+3] ^ sync_c[NI+3];
	wire fc2_edge = sync_b[NI+1] ^ sync_c[NI+1];
	wire [NI-1:0] sdi = sync_b[NI-1:0];

	// Straps only update after two equal samples, so decode never sees a half-changed set
	logic [3:0] strap_q;
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			strap_q <= '0;
		end else if (strap_now == strap_prev) begin
			strap_q <= strap_now;
		end
	end

	// Frame clock one toggles in sample mode, so only a level held for as long as the
	// longest accepted frame counts as the stream request; a plain level would flicker
	logic [dmc_pkg::PERIOD_W-1:0] high_run;
	wire pin_held = (high_run == dmc_pkg::RATIO_HALVE_SINGLE);
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			high_run <= '0;
		end else if (!fc1) begin
			high_run <= '0;
		end else if (!pin_held) begin
			high_run <= high_run + 16'h0001;
		end
	end

	// Register file
	logic [dmc_pkg::DATA_W-1:0] control;
	logic [dmc_pkg::DATA_W-1:0] mode;
	logic [dmc_pkg::DATA_W-1:0] clksel;
	wire wr_control = reg_write_in & (reg_addr_in == dmc_pkg::REG_CONTROL);
	wire wr_mode = reg_write_in & (reg_addr_in == dmc_pkg::REG_MODE);
	wire wr_clksel = reg_write_in & (reg_addr_in == dmc_pkg::REG_CLKSEL);
	wire control_port_enable = control[dmc_pkg::CTL_CONTROL_PORT_ENABLE];
	wire control_port_enable_write = wr_control & reg_wdata_in[dmc_pkg::CTL_CONTROL_PORT_ENABLE] & ~control_port_enable;
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			control <= dmc_pkg::CONTROL_RESET;
			mode <= dmc_pkg::MODE_RESET;
			clksel <= dmc_pkg::CLKSEL_RESET;
		end else if (control_port_enable_write) begin
			control <= dmc_pkg::CONTROL_RESET | dmc_pkg::CONTROL_PORT_ENABLE_MASK;
			mode <= dmc_pkg::MODE_RESET;
			clksel <= dmc_pkg::CLKSEL_RESET;
		end else begin
			// Port enable is sticky until reset
			if (wr_control) control <= reg_wdata_in | (control & dmc_pkg::CONTROL_PORT_ENABLE_MASK);
			if (wr_mode) mode <= reg_wdata_in;
			if (wr_clksel) clksel <= reg_wdata_in;
		end
	end

	// Effective configuration
	wire standalone = ~control_port_enable;
	wire [1:0] mode_speed = mode[dmc_pkg::MODE_SPEED_LO +: 2];
	wire [2:0] mode_fmt = mode[dmc_pkg::MODE_FMT_LO +: 3];
	wire eff_bitstream = standalone ? pin_held : (mode_speed == dmc_pkg::SPEED_BITSTREAM);
	wire [1:0] sa_speed = (strap_q[3:2] == dmc_pkg::STRAP_QUAD) ? dmc_pkg::SPEED_QUAD :
		(strap_q[3:2] == dmc_pkg::STRAP_DOUBLE) ? dmc_pkg::SPEED_DOUBLE : dmc_pkg::SPEED_SINGLE;
	wire [1:0] eff_speed = eff_bitstream ? dmc_pkg::SPEED_BITSTREAM :
		(standalone ? sa_speed : mode_speed);
	wire [2:0] eff_format = standalone ? {1'b0, strap_q[1:0]} : mode_fmt;
	wire [2:0] bs_sel = standalone ? strap_q[2:0] : mode_fmt;
	wire [3:0] bs_ratio = bs_sel[2] ? dmc_pkg::BS_RATIO_128[bs_sel[1:0]] :
		dmc_pkg::BS_RATIO_64[bs_sel[1:0]];
	wire [7:0] eff_osr = eff_bitstream ?
		(bs_sel[2] ? dmc_pkg::OSR_BS_HIGH : dmc_pkg::OSR_BS_LOW) :
		(eff_speed == dmc_pkg::SPEED_QUAD) ? dmc_pkg::OSR_QUAD :
		(eff_speed == dmc_pkg::SPEED_DOUBLE) ? dmc_pkg::OSR_DOUBLE : dmc_pkg::OSR_SINGLE;
	wire eff_deemph = ~eff_bitstream & (standalone ? (strap_q[3:2] == dmc_pkg::STRAP_SS_DEEMPH) :
		control[dmc_pkg::CTL_DEEMPH]);
	wire eff_filter = standalone ? dmc_pkg::FILT_FAST : control[dmc_pkg::CTL_FILT];
	wire [NI-1:0] pair_sel = standalone ? '0 : clksel[NI-1:0];
	wire pair_two_used = |pair_sel;

	// Master clock ratio, measured as system clocks per frame of pair one
	logic fm1_rise;
	logic fm2_rise;
	logic fm1_slip;
	logic fm2_slip;
	logic [dmc_pkg::PERIOD_W-1:0] fc1_period;
	dmc_frame_meter u_meter_one (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.level_in(fc1), .rise_out(fm1_rise), .period_out(fc1_period), .slip_out(fm1_slip));
	dmc_frame_meter u_meter_two (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.level_in(fc2), .rise_out(fm2_rise), .period_out(), .slip_out(fm2_slip));
	wire halve_ok = control_port_enable & control[dmc_pkg::CTL_HALVE];
	wire [dmc_pkg::PERIOD_W-1:0] r_min = (eff_speed == dmc_pkg::SPEED_QUAD) ? dmc_pkg::RATIO_MIN_QUAD :
		(eff_speed == dmc_pkg::SPEED_DOUBLE) ? dmc_pkg::RATIO_MIN_DOUBLE : dmc_pkg::RATIO_MIN_SINGLE;
	wire [dmc_pkg::PERIOD_W-1:0] r_max = (eff_speed == dmc_pkg::SPEED_QUAD) ?
		(halve_ok ? dmc_pkg::RATIO_HALVE_QUAD : dmc_pkg::RATIO_MAX_QUAD) :
		(eff_speed == dmc_pkg::SPEED_DOUBLE) ?
		(halve_ok ? dmc_pkg::RATIO_HALVE_DOUBLE : dmc_pkg::RATIO_MAX_DOUBLE) :
		(halve_ok ? dmc_pkg::RATIO_HALVE_SINGLE : dmc_pkg::RATIO_MAX_SINGLE);
	wire ratio_ok = eff_bitstream | ((fc1_period >= r_min) & (fc1_period <= r_max));

	// Power sequencing; in stream mode frame clock one is static, so bit clocks are counted
	dmc_pkg::dmc_state_t state;
	dmc_pkg::dmc_state_t next_state;
	logic [dmc_pkg::FRAME_CNT_W-1:0] frame_count;
	logic [dmc_pkg::FRAME_CNT_W-1:0] next_frame_count;
	wire tick = eff_bitstream ? bc1_rise : fm1_rise;
	wire [dmc_pkg::FRAME_CNT_W-1:0] pwrup_frames = (eff_speed == dmc_pkg::SPEED_QUAD) ?
		dmc_pkg::PWRUP_FRAMES_QUAD : (eff_speed == dmc_pkg::SPEED_DOUBLE) ?
		dmc_pkg::PWRUP_FRAMES_DOUBLE : dmc_pkg::PWRUP_FRAMES_SINGLE;
	wire seq_done = tick & (frame_count == pwrup_frames - 12'h001);
	wire [dmc_pkg::FRAME_CNT_W-1:0] count_step = tick ? (frame_count + 12'h001) : frame_count;
	wire power_down_bit = control[dmc_pkg::CTL_PDN];
	always_comb begin
		next_state = state;
		next_frame_count = count_step;
		unique case (state)
			dmc_pkg::ST_SA_POWERUP: begin
				if (control_port_enable) begin
					next_state = dmc_pkg::ST_CP_DOWN;
				end else if (seq_done) begin
					next_state = dmc_pkg::ST_SA_RUN;
				end
			end
			dmc_pkg::ST_SA_RUN: begin
				if (control_port_enable) next_state = dmc_pkg::ST_CP_DOWN;
			end
			dmc_pkg::ST_CP_DOWN: begin
				next_frame_count = '0;
				if (!power_down_bit) next_state = dmc_pkg::ST_CP_POWERUP;
			end
			dmc_pkg::ST_CP_POWERUP: begin
				if (power_down_bit) begin
					next_state = dmc_pkg::ST_CP_DOWN;
				end else if (seq_done) begin
					next_state = dmc_pkg::ST_CP_RUN;
				end
			end
			dmc_pkg::ST_CP_RUN: begin
				if (power_down_bit) next_state = dmc_pkg::ST_CP_DOWN;
			end
			default: begin
				next_state = dmc_pkg::ST_SA_POWERUP;
				next_frame_count = '0;
			end
		endcase
	end
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= dmc_pkg::ST_SA_POWERUP;
			frame_count <= '0;
		end else begin
			state <= next_state;
			frame_count <= next_frame_count;
		end
	end
	wire running = (state == dmc_pkg::ST_SA_RUN) | (state == dmc_pkg::ST_CP_RUN);

	// Retiming when either pair slips while any input uses pair two
	logic [3:0] retime_count;
	wire slip = pair_two_used & (fm1_slip | fm2_slip);
	wire retiming = (retime_count != 4'h0);
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			retime_count <= 4'h0;
		end else if (slip) begin
			retime_count <= dmc_pkg::RETIME_FRAMES;
		end else if (retiming & fm1_rise) begin
			retime_count <= retime_count - 4'h1;
		end
	end
	wire muted = ~running | retiming;
	wire mute_assert = muted & control[dmc_pkg::CTL_MUTE_EN];
	wire mute_level = control[dmc_pkg::CTL_MUTE_POL] ? mute_assert : ~mute_assert;

	// Per input capture on the selected pair
	for (genvar i = 0; i < NI; i++) begin : g_input
		logic [SW-1:0] shift;
		wire bit_rise = pair_sel[i] ? bc2_rise : bc1_rise;
		wire frame_edge = pair_sel[i] ? fc2_edge : fc1_edge;
		always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				shift <= '0;
				sample_word_out[i*SW +: SW] <= '0;
				sample_valid_out[i] <= 1'b0;
			end else begin
				if (bit_rise) shift <= {shift[SW-2:0], sdi[i]};
				if (frame_edge) sample_word_out[i*SW +: SW] <= shift;
				sample_valid_out[i] <= frame_edge & ~muted & ~eff_bitstream;
			end
		end
	end

	wire [dmc_pkg::DATA_W-1:0] status = {1'b0, standalone, ratio_ok, retiming, running,
		eff_bitstream, eff_speed};
	wire [dmc_pkg::DATA_W-1:0] read_mux = (reg_addr_in == dmc_pkg::REG_CONTROL) ? control :
		(reg_addr_in == dmc_pkg::REG_MODE) ? mode :
		(reg_addr_in == dmc_pkg::REG_CLKSEL) ? clksel :
		(reg_addr_in == dmc_pkg::REG_STATUS) ? status : 8'h00;
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 8'h00;
			quiescent_reference_out <= 1'b0;
			speed_mode_out <= dmc_pkg::SPEED_SINGLE;
			iface_format_out <= dmc_pkg::FMT_LEFT_JUST;
			deemphasis_out <= 1'b0;
			bitstream_mode_out <= 1'b0;
			oversample_ratio_out <= dmc_pkg::OSR_SINGLE;
			bitstream_ratio_out <= 4'h0;
			filter_rolloff_out <= dmc_pkg::FILT_FAST;
			ratio_ok_out <= 1'b0;
			retiming_out <= 1'b0;
			pair_active_out <= 4'h0;
			mute_out <= 4'h0;
		end else begin
			reg_rdata_out <= reg_read_in ? read_mux : 8'h00;
			quiescent_reference_out <= running;
			speed_mode_out <= eff_speed;
			iface_format_out <= eff_format;
			deemphasis_out <= eff_deemph;
			bitstream_mode_out <= eff_bitstream;
			oversample_ratio_out <= eff_osr;
			bitstream_ratio_out <= eff_bitstream ? bs_ratio : 4'h0;
			filter_rolloff_out <= eff_filter;
			ratio_ok_out <= ratio_ok;
			retiming_out <= retiming;
			pair_active_out <= {4{~muted}};
			mute_out <= {4{mute_level}};
		end
	end
endmodule : dmc_device

//--- hw/dmc_pkg.sv
package dmc_pkg;
	localparam int NUM_INPUTS = 4;
	localparam int SAMPLE_W = 24;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PERIOD_W = 16;
	localparam int FRAME_CNT_W = 12;
	localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_MODE = 4'h1;
	localparam logic [ADDR_W-1:0] REG_CLKSEL = 4'h2;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;
	// Control register fields
	localparam int CTL_CONTROL_PORT_ENABLE = 0;
	localparam int CTL_PDN = 1;
	localparam int CTL_HALVE = 2;
	localparam int CTL_FILT = 3;
	localparam int CTL_DEEMPH = 4;
	localparam int CTL_MUTE_EN = 5;
	localparam int CTL_MUTE_POL = 6;
	localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h22;
	localparam logic [DATA_W-1:0] CONTROL_PORT_ENABLE_MASK = 8'h01;
	localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] CLKSEL_RESET = 8'h00;
	// Mode register fields
	localparam int MODE_SPEED_LO = 0;
	localparam int MODE_FMT_LO = 2;
	typedef enum logic [1:0] {
		SPEED_SINGLE = 2'h0,
		SPEED_DOUBLE = 2'h1,
		SPEED_QUAD = 2'h2,
		SPEED_BITSTREAM = 2'h3
	} dmc_speed_t;
	localparam logic [2:0] FMT_LEFT_JUST = 3'h0;
	localparam logic [2:0] FMT_I2S = 3'h1;
	localparam logic [2:0] FMT_RIGHT_16 = 3'h2;
	localparam logic [2:0] FMT_RIGHT_24 = 3'h3;
	localparam logic [1:0] STRAP_SS_DEEMPH = 2'h1;
	localparam logic [1:0] STRAP_DOUBLE = 2'h2;
	localparam logic [1:0] STRAP_QUAD = 2'h3;
	localparam logic FILT_FAST = 1'b0;
	localparam logic [7:0] OSR_SINGLE = 8'h80;
	localparam logic [7:0] OSR_DOUBLE = 8'h40;
	localparam logic [7:0] OSR_QUAD = 8'h20;
	localparam logic [7:0] OSR_BS_LOW = 8'h40;
	localparam logic [7:0] OSR_BS_HIGH = 8'h80;
	localparam logic [3:0] BS_RATIO_64 [4] = '{4'h4, 4'h6, 4'h8, 4'hC};
	localparam logic [3:0] BS_RATIO_128 [4] = '{4'h2, 4'h3, 4'h4, 4'h6};
	localparam logic [FRAME_CNT_W-1:0] PWRUP_FRAMES_SINGLE = 12'h200;
	localparam logic [FRAME_CNT_W-1:0] PWRUP_FRAMES_DOUBLE = 12'h400;
	localparam logic [FRAME_CNT_W-1:0] PWRUP_FRAMES_QUAD = 12'h800;
	localparam logic [PERIOD_W-1:0] RATIO_MIN_SINGLE = 16'h0100;
	localparam logic [PERIOD_W-1:0] RATIO_MAX_SINGLE = 16'h0300;
	localparam logic [PERIOD_W-1:0] RATIO_HALVE_SINGLE = 16'h0400;
	localparam logic [PERIOD_W-1:0] RATIO_MIN_DOUBLE = 16'h0080;
	localparam logic [PERIOD_W-1:0] RATIO_MAX_DOUBLE = 16'h0180;
	localparam logic [PERIOD_W-1:0] RATIO_HALVE_DOUBLE = 16'h0200;
	localparam logic [PERIOD_W-1:0] RATIO_MIN_QUAD = 16'h0040;
	localparam logic [PERIOD_W-1:0] RATIO_MAX_QUAD = 16'h00C0;
	localparam logic [PERIOD_W-1:0] RATIO_HALVE_QUAD = 16'h0100;
	localparam logic [PERIOD_W-1:0] SYNC_TOL = 16'h0001;
	localparam logic [3:0] RETIME_FRAMES = 4'h2;
	typedef enum logic [4:0] {
		ST_SA_POWERUP = 5'b00001,
		ST_SA_RUN = 5'b00010,
		ST_CP_DOWN = 5'b00100,
		ST_CP_POWERUP = 5'b01000,
		ST_CP_RUN = 5'b10000
	} dmc_state_t;
	// Source side clock generation, in master clock cycles and bit clocks
	localparam logic [3:0] SRC_BIT_HALF = 4'h4;
	localparam logic [5:0] SRC_BITS_PER_HALF_FRAME = 6'h20;
endpackage : dmc_pkg

//--- hw/dmc_link_if.sv
`timescale 1ns/1ps
interface dmc_link_if;
	logic [3:0] mode_strap;
	logic frame_clock_one;
	logic bit_clock_one;
	logic frame_clock_two;
	logic bit_clock_two;
	logic [dmc_pkg::NUM_INPUTS-1:0] serial_data_input;
	modport device (
		input mode_strap,
		input frame_clock_one,
		input bit_clock_one,
		input frame_clock_two,
		input bit_clock_two,
		input serial_data_input
	);
	modport source (
		output mode_strap,
		output frame_clock_one,
		output bit_clock_one,
		output frame_clock_two,
		output bit_clock_two,
		output serial_data_input
	);
endinterface : dmc_link_if

//--- hw/dmc_source.sv
`timescale 1ns/1ps
module dmc_source (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	dmc_link_if.source link,
	input wire logic [3:0] strap_in,
	input wire logic pair_two_enable_in,
	input wire logic bitstream_enable_in,
	input wire logic [dmc_pkg::NUM_INPUTS*dmc_pkg::SAMPLE_W-1:0] word_in,
	output logic word_take_out
);
	localparam int NI = dmc_pkg::NUM_INPUTS;
	localparam int SW = dmc_pkg::SAMPLE_W;
	logic [3:0] div;
	logic bclk;
	logic [5:0] bit_cnt;
	logic fclk;
	logic [3:0] strap;
	logic [NI*SW-1:0] shift;
	wire half_bit = (div == dmc_pkg::SRC_BIT_HALF - 4'h1);
	wire fall = half_bit & bclk;
	wire frame_toggle = fall & (bit_cnt == dmc_pkg::SRC_BITS_PER_HALF_FRAME - 6'h01);
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div <= 4'h0;
			bclk <= 1'b0;
			bit_cnt <= 6'h00;
			fclk <= 1'b0;
			strap <= 4'h0;
			shift <= '0;
			word_take_out <= 1'b0;
		end else begin
			strap <= strap_in;
			div <= half_bit ? 4'h0 : div + 4'h1;
			if (half_bit) bclk <= ~bclk;
			word_take_out <= frame_toggle;
			if (fall) begin
				bit_cnt <= frame_toggle ? 6'h00 : bit_cnt + 6'h01;
				for (int i = 0; i < NI; i++) begin
					shift[i*SW +: SW] <= {shift[i*SW +: SW-1], 1'b0};
				end
			end
			if (frame_toggle) begin
				fclk <= ~fclk;
				shift <= word_in;
			end
		end
	end
	// Both pairs come from one divider chain, so they stay locked at equal rate
	assign link.mode_strap = strap;
	assign link.bit_clock_one = bclk;
	assign link.frame_clock_one = bitstream_enable_in | fclk;
	assign link.bit_clock_two = pair_two_enable_in & bclk;
	assign link.frame_clock_two = pair_two_enable_in & fclk;
	for (genvar i = 0; i < NI; i++) begin : g_data
		assign link.serial_data_input[i] = shift[i*SW + SW - 1];
	end
endmodule : dmc_source

//--- sim/dmc_link_sva.sv
`timescale 1ns/1ps
module dmc_link_chk (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic frame_clock_one,
	input wire logic frame_clock_two,
	input wire logic bit_clock_one,
	input wire logic quiescent_reference_out,
	input wire logic [1:0] speed_mode_out,
	input wire logic bitstream_mode_out,
	input wire logic [7:0] oversample_ratio_out,
	input wire logic [3:0] bitstream_ratio_out,
	input wire logic filter_rolloff_out,
	input wire logic retiming_out,
	input wire logic [3:0] pair_active_out,
	input wire logic [dmc_pkg::NUM_INPUTS-1:0] sample_valid_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);
	chk_ref_low_release: assert property ($rose(reset_n_in) |-> !quiescent_reference_out)
		else $error("reference high at reset release");
	chk_quad_osr: assert property ((speed_mode_out == 2'h2) [*3] |-> oversample_ratio_out == 8'h20)
		else $error("quad speed oversampling wrong");
	chk_double_osr: assert property ((speed_mode_out == 2'h1) [*3] |-> oversample_ratio_out == 8'h40)
		else $error("double speed oversampling wrong");
	chk_ratio_idle: assert property (!bitstream_mode_out [*3] |-> bitstream_ratio_out == 4'h0)
		else $error("stream ratio set outside stream mode");
	chk_retime_inactive: assert property (retiming_out |-> pair_active_out == 4'h0)
		else $error("pairs active during retime");
	// Valid is registered, so one cycle of slack after retime starts
	chk_retime_quiet: assert property (retiming_out [*2] |-> sample_valid_out == '0)
		else $error("sample valid during retime");
	chk_active_running: assert property (pair_active_out != 4'h0 |-> quiescent_reference_out)
		else $error("pairs active before power-up");
	chk_pair_two_derived: assert property (frame_clock_two |-> frame_clock_one)
		else $error("frame clock two not derived from one");
	chk_bit_half: assert property ($rose(bit_clock_one) |=> bit_clock_one [*3])
		else $error("bit clock half period short");
	cover property ($rose(retiming_out));
	cover property ($rose(quiescent_reference_out));
	cover property ($rose(bitstream_mode_out));
	cover property ($rose(filter_rolloff_out));
endmodule : dmc_link_chk

//--- sim/tb_dac_mode_and_clock_config.sv
`timescale 1ns/1ps
module tb_dac_mode_and_clock_config;
	typedef struct {
		logic bs;
		logic [3:0] strap;
		logic [1:0] speed;
		logic [2:0] fmt;
		logic deemphasis_select;
		logic [7:0] osr;
		logic [3:0] ratio;
	} dmc_row_t;
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [3:0] strap = 4'h0;
	logic p2en = 1'b0;
	logic bsen = 1'b1;
	logic [7:0] rdata_q, osr_q, rdata;
	logic [1:0] speed_q;
	logic [2:0] fmt_q;
	logic [3:0] ratio_q, active_q, mute_q, valid_q;
	logic ref_q, dem_q, bsm_q, filt_q, retime_q;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	int n;
	// Stream rows last: leaving stream mode may need half a frame to be seen
	dmc_row_t rows [12] = '{
		'{1'b0, 4'h0, 2'h0, 3'h0, 1'b0, 8'h80, 4'h0}, '{1'b0, 4'h5, 2'h0, 3'h1, 1'b1, 8'h80, 4'h0},
		'{1'b0, 4'hA, 2'h1, 3'h2, 1'b0, 8'h40, 4'h0}, '{1'b0, 4'hF, 2'h2, 3'h3, 1'b0, 8'h20, 4'h0},
		'{1'b1, 4'h0, 2'h3, 3'h0, 1'b0, 8'h40, 4'h4}, '{1'b1, 4'h1, 2'h3, 3'h0, 1'b0, 8'h40, 4'h6},
		'{1'b1, 4'h2, 2'h3, 3'h0, 1'b0, 8'h40, 4'h8}, '{1'b1, 4'h3, 2'h3, 3'h0, 1'b0, 8'h40, 4'hC},
		'{1'b1, 4'h4, 2'h3, 3'h0, 1'b0, 8'h80, 4'h2}, '{1'b1, 4'h5, 2'h3, 3'h0, 1'b0, 8'h80, 4'h3},
		'{1'b1, 4'h6, 2'h3, 3'h0, 1'b0, 8'h80, 4'h4}, '{1'b1, 4'h7, 2'h3, 3'h0, 1'b0, 8'h80, 4'h6}};
	logic [7:0] cp_mode [3] = '{8'h01, 8'h0F, 8'h13};
	logic [7:0] cp_osr [3] = '{8'h40, 8'h40, 8'h80};
	logic [3:0] cp_ratio [3] = '{4'h0, 4'hC, 4'h2};

	dmc_link_if link_bus ();
	dmc_source dmc_source_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.link(link_bus.source), .strap_in(strap), .pair_two_enable_in(p2en),
		.bitstream_enable_in(bsen), .word_in({4{24'hC3A51E}}), .word_take_out());
	dmc_device dmc_device_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.link(link_bus.device), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_write_in(reg_write), .reg_read_in(reg_read), .reg_rdata_out(rdata_q),
		.quiescent_reference_out(ref_q), .speed_mode_out(speed_q), .iface_format_out(fmt_q),
		.deemphasis_out(dem_q), .bitstream_mode_out(bsm_q), .oversample_ratio_out(osr_q),
		.bitstream_ratio_out(ratio_q), .filter_rolloff_out(filt_q), .ratio_ok_out(),
		.retiming_out(retime_q), .pair_active_out(active_q), .mute_out(mute_q),
		.sample_word_out(), .sample_valid_out(valid_q));
	dmc_link_chk dmc_link_chk_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.frame_clock_one(link_bus.frame_clock_one), .frame_clock_two(link_bus.frame_clock_two),
		.bit_clock_one(link_bus.bit_clock_one), .quiescent_reference_out(ref_q),
		.speed_mode_out(speed_q), .bitstream_mode_out(bsm_q), .oversample_ratio_out(osr_q),
		.bitstream_ratio_out(ratio_q), .filter_rolloff_out(filt_q), .retiming_out(retime_q),
		.pair_active_out(active_q), .sample_valid_out(valid_q));

	always #20 clk_sys_in = ~clk_sys_in;

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys_in);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys_in);
		reg_read <= 1'b0;
		@(negedge clk_sys_in);
		d = rdata_q;
	endtask : rd

	// Bounded wait on the reference (which=0) or the retime flag (which=1)
	task automatic wait_lvl(input bit which, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while ((which ? retime_q : ref_q) !== lvl && cnt < lim) begin
			@(posedge clk_sys_in);
			cnt++;
		end
	endtask : wait_lvl

	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	initial begin
		@(negedge clk_sys_in);
		check(ref_q, 1'b0);
		@(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		// Stream pin must be held 1024 clocks first, then 512 bit clocks are counted
		wait_lvl(1'b0, 1'b1, 10000, n);
		check(n >= 5080 && n <= 5250, 1'b1);
		$display("test standalone power-up done");
		foreach (rows[i]) begin
			@(posedge clk_sys_in);
			strap <= rows[i].strap;
			bsen <= rows[i].bs;
			repeat (1200) @(posedge clk_sys_in);
			@(negedge clk_sys_in);
			check(speed_q, rows[i].speed);
			check(osr_q, rows[i].osr);
			check(ratio_q, rows[i].ratio);
			check(bsm_q, rows[i].bs);
			check(filt_q, 1'b0);
			if (!rows[i].bs) begin
				check(fmt_q, rows[i].fmt);
				check(dem_q, rows[i].deemphasis_select);
			end
		end
		$display("test standalone straps done");
		@(posedge clk_sys_in);
		bsen <= 1'b0;
		wr(dmc_pkg::REG_MODE, 8'h1F);
		wr(dmc_pkg::REG_CONTROL, 8'h01);
		rd(dmc_pkg::REG_CONTROL, rdata);
		check(rdata, 8'h23);
		rd(dmc_pkg::REG_MODE, rdata);
		check(rdata, 8'h00);
		wr(dmc_pkg::REG_CONTROL, 8'h22);
		rd(dmc_pkg::REG_CONTROL, rdata);
		check(rdata, 8'h23);
		wr(4'h7, 8'hFF);
		rd(4'h7, rdata);
		check(rdata, 8'h00);
		check(ref_q, 1'b0);
		rd(dmc_pkg::REG_STATUS, rdata);
		check(rdata & 8'h40, 8'h00);
		for (int k = 0; k < 3; k++) begin
			wr(dmc_pkg::REG_MODE, cp_mode[k]);
			repeat (4) @(posedge clk_sys_in);
			@(negedge clk_sys_in);
			check(speed_q, cp_mode[k][1:0]);
			check(osr_q, cp_osr[k]);
			check(ratio_q, cp_ratio[k]);
			check(bsm_q, k > 0);
		end
		wr(dmc_pkg::REG_CONTROL, 8'h0B);
		repeat (4) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		check(filt_q, 1'b1);
		$display("test control port fields done");
		wr(dmc_pkg::REG_CONTROL, 8'h21);
		wait_lvl(1'b0, 1'b1, 10000, n);
		check(n >= 4000 && n < 10000, 1'b1);
		@(negedge clk_sys_in);
		check(active_q, 4'hF);
		$display("test control port power-up done");
		wr(dmc_pkg::REG_CLKSEL, 8'h01);
		p2en <= 1'b1;
		wr(dmc_pkg::REG_MODE, 8'h00);
		wait_lvl(1'b1, 1'b0, 8000, n);
		@(posedge clk_sys_in);
		bsen <= 1'b1;
		repeat (300) @(posedge clk_sys_in);
		bsen <= 1'b0;
		wait_lvl(1'b1, 1'b1, 3000, n);
		check(n < 3000, 1'b1);
		@(negedge clk_sys_in);
		check(active_q, 4'h0);
		check(mute_q, 4'h0);
		wr(dmc_pkg::REG_CONTROL, 8'h61);
		repeat (3) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		check(mute_q, 4'hF);
		check(bsm_q, 1'b0);
		wait_lvl(1'b1, 1'b0, 8000, n);
		check(n < 8000, 1'b1);
		$display("test retime done");
		@(posedge clk_sys_in);
		reset_n_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		check(ref_q, 1'b0);
		@(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		rd(dmc_pkg::REG_CONTROL, rdata);
		check(rdata, 8'h22);
		rd(dmc_pkg::REG_CLKSEL, rdata);
		check(rdata, 8'h00);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule : tb_dac_mode_and_clock_config
